// ===== logic/host_port_pkg.sv
// package: constants and carrier types for the host index/data port
package host_port_pkg;

   // ----------------------------------------
   // memory and register space
   // ----------------------------------------
   localparam int unsigned PKT_MEM_BYTES = 16384;
   localparam int unsigned PKT_ADDR_W = 14;
   localparam int unsigned REG_IDX_W = 8;
   localparam logic [7:0] GP_OUT_REG_OFFSET = 8'h1f;
   localparam logic [7:0] MEM_ADDR_LO_OFFSET = 8'hf4;
   localparam logic [7:0] MEM_ADDR_HI_OFFSET = 8'hf5;
   localparam logic [7:0] MEM_DATA_OFFSET = 8'hf2;
   localparam logic [7:0] VENDOR_ID_LO_OFFSET = 8'h28;
   localparam logic [7:0] VENDOR_ID_HI_OFFSET = 8'h29;
   localparam logic [7:0] PRODUCT_ID_LO_OFFSET = 8'h2a;
   localparam logic [7:0] PRODUCT_ID_HI_OFFSET = 8'h2b;
   localparam int unsigned GP_OUT_W = 3;
   localparam logic [2:0] GP_OUT_RESET = 3'h0;
   // arbitrary neutral identity values
   localparam logic [15:0] VENDOR_ID_RESET = 16'h0000;
   localparam logic [15:0] PRODUCT_ID_RESET = 16'h0000;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic read_inv;
      logic write_inv;
      logic select_inv;
      logic irq_inv;
      logic led_mode;
      logic valid;
   } cfg_load_t;

   typedef struct packed {
      logic vendor_valid;
      logic [15:0] vendor_id;
      logic [15:0] product_id;
   } id_load_t;

   typedef struct packed {
      logic width8;
      logic irq_low;
      logic select_high;
      logic irq_open_drain;
   } straps_t;

   typedef struct packed {
      logic full_duplex;
      logic speed_10m;
   } link_state_t;

endpackage : host_port_pkg

// ===== logic/packet_mem.sv
// file: byte-lane packet memory with registered read data
`timescale 1ns/100ps
module packet_mem #(
   parameter int unsigned ADDR_W = 14
) (
   input wire logic clk,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic we,
   input wire logic word,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata
);
   logic [7:0] mem [0:(2**ADDR_W)-1];
   logic [ADDR_W-1:0] addr_hi;

   assign addr_hi = addr + ADDR_W'(1);

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata[7:0];
         if (word) begin
            mem[addr_hi] <= wdata[15:8];
         end
      end
      rdata <= {word ? mem[addr_hi] : 8'h00, mem[addr]};
   end
endmodule : packet_mem

// ===== logic/host_index_data_port.sv
// file: host index/data port pin logic
//
// Summary of operation
// - port-select high reaches data port, low reaches index port each cycle.
// - read strobe active low after reset, invertible by loaded configuration.
// - write strobe active low after reset, invertible by loaded configuration.
// - chip select active low by default, polarity changed by loaded configuration.
// - interrupt active high by default, polarity from configuration or strap.
// - interrupt polarity strap high at reset makes interrupt active low.
// - low lanes carry bits 7..0; high lanes carry 15..8 in 16-bit mode.
// - width strap high selects 8-bit bus; high lanes get alternate functions.
// - in 8-bit mode wake strap high makes chip select active high.
// - in 8-bit mode the wake output signals remote wake-up events.
// - indicator mode 1: drive low on full duplex, float on half.
// - indicator mode 0: drive low at 10M, float at 100M.
// - in 8-bit mode three general outputs follow register 1Fh.
// - in 8-bit mode general output strap high makes interrupt open-drain, else push-pull.
// - byte or word access to 16K-byte packet memory, by bus width.
// - vendor and product ids load from configuration memory when present.
`timescale 1ns/100ps
module host_index_data_port #(
   parameter int unsigned ADDR_W = host_port_pkg::PKT_ADDR_W
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic host_read_strobe,
   input wire logic host_write_strobe,
   input wire logic chip_select,
   input wire logic port_select,
   input wire logic [7:0] data_low_lanes_in,
   output logic [7:0] data_low_lanes_out,
   output logic data_low_lanes_oe_n,
   input wire logic [7:0] data_high_lanes_in,
   output logic [7:0] data_high_lanes_out,
   output logic [7:0] data_high_lanes_oe_n,
   input wire logic width_strap_pin,
   input wire logic irq_polarity_strap_pin,
   input wire logic wake_strap_pin,
   input wire logic irq_drive_type_strap,
   input wire host_port_pkg::cfg_load_t cfg_load,
   input wire host_port_pkg::id_load_t id_load,
   input wire host_port_pkg::link_state_t link_state,
   input wire logic irq_event,
   input wire logic wake_event,
   output logic irq_out,
   output logic irq_oe_n,
   output logic [7:0] reg_index,
   output logic [15:0] vendor_id,
   output logic [15:0] product_id
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      host_port_pkg::straps_t straps;
      logic strap_done;
      logic read_inv;
      logic write_inv;
      logic select_inv;
      logic irq_inv;
      logic led_mode;
      logic rd_q;
      logic wr_q;
      logic [7:0] index;
      logic [ADDR_W-1:0] mem_addr;
      logic [2:0] gp_out;
      logic [15:0] vendor;
      logic [15:0] product;
      logic [15:0] rdata;
      logic drive;
      logic wake;
      logic mem_fetch;
   } state_t;

   state_t s_q, s_d;
   logic sel, rd, wr, rd_start, wr_start, word, mem_we, mem_hit;
   logic [15:0] wdata, mem_rdata;
   logic duplex_low;

   // ----------------------------------------
   // pin decode
   // ----------------------------------------
   // strap-selected active-high select in 8-bit mode, flipped again by loaded config
   assign sel = chip_select ^ ~(s_q.straps.width8 & s_q.straps.select_high) ^ s_q.select_inv;
   assign rd = sel & (host_read_strobe ^ ~s_q.read_inv);
   assign wr = sel & (host_write_strobe ^ ~s_q.write_inv);
   assign rd_start = rd & ~s_q.rd_q;
   assign wr_start = wr & ~s_q.wr_q;
   assign word = ~s_q.straps.width8;
   assign wdata = {word ? data_high_lanes_in : 8'h00, data_low_lanes_in};
   // the data port at the memory-data index goes to packet memory
   assign mem_hit = port_select && s_q.index == host_port_pkg::MEM_DATA_OFFSET;
   assign mem_we = wr_start & mem_hit;

   packet_mem #(.ADDR_W(ADDR_W)) u_mem (
      .clk(clk),
      .addr(s_q.mem_addr),
      .we(mem_we),
      .word(word),
      .wdata(wdata),
      .rdata(mem_rdata)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.rd_q = rd;
      s_d.wr_q = wr;
      s_d.wake = s_q.straps.width8 & wake_event;
      // the memory read register follows the stepped address, so the fetched word is caught once here
      s_d.mem_fetch = rd_start & mem_hit;
      if (s_q.mem_fetch) begin
         s_d.rdata = mem_rdata;
      end
      // straps caught once, on the first clock after reset release
      if (!s_q.strap_done) begin
         s_d.strap_done = 1'b1;
         s_d.straps.width8 = width_strap_pin;
         s_d.straps.irq_low = irq_polarity_strap_pin;
         s_d.straps.select_high = wake_strap_pin;
         s_d.straps.irq_open_drain = irq_drive_type_strap;
      end
      if (cfg_load.valid) begin
         s_d.read_inv = cfg_load.read_inv;
         s_d.write_inv = cfg_load.write_inv;
         s_d.select_inv = cfg_load.select_inv;
         s_d.irq_inv = cfg_load.irq_inv;
         s_d.led_mode = cfg_load.led_mode;
      end
      if (id_load.vendor_valid) begin
         s_d.vendor = id_load.vendor_id;
         s_d.product = id_load.product_id;
      end
      if (wr_start) begin
         if (!port_select) begin
            s_d.index = data_low_lanes_in;
         end else begin
            unique case (s_q.index)
               host_port_pkg::GP_OUT_REG_OFFSET: s_d.gp_out = data_low_lanes_in[2:0];
               host_port_pkg::MEM_ADDR_LO_OFFSET: s_d.mem_addr[7:0] = data_low_lanes_in;
               host_port_pkg::MEM_ADDR_HI_OFFSET: s_d.mem_addr[ADDR_W-1:8] = data_low_lanes_in[ADDR_W-9:0];
               host_port_pkg::MEM_DATA_OFFSET: s_d.mem_addr = s_q.mem_addr + (word ? ADDR_W'(2) : ADDR_W'(1));
               default: s_d.index = s_q.index;
            endcase
         end
      end
      if (rd_start) begin
         s_d.drive = 1'b1;
         if (!port_select) begin
            s_d.rdata = {8'h00, s_q.index};
         end else begin
            unique case (s_q.index)
               host_port_pkg::GP_OUT_REG_OFFSET: s_d.rdata = {13'h0000, s_q.gp_out};
               host_port_pkg::MEM_ADDR_LO_OFFSET: s_d.rdata = {8'h00, s_q.mem_addr[7:0]};
               host_port_pkg::MEM_ADDR_HI_OFFSET: s_d.rdata = 16'(s_q.mem_addr[ADDR_W-1:8]);
               host_port_pkg::VENDOR_ID_LO_OFFSET: s_d.rdata = {8'h00, s_q.vendor[7:0]};
               host_port_pkg::VENDOR_ID_HI_OFFSET: s_d.rdata = {8'h00, s_q.vendor[15:8]};
               host_port_pkg::PRODUCT_ID_LO_OFFSET: s_d.rdata = {8'h00, s_q.product[7:0]};
               host_port_pkg::PRODUCT_ID_HI_OFFSET: s_d.rdata = {8'h00, s_q.product[15:8]};
               host_port_pkg::MEM_DATA_OFFSET: s_d.mem_addr = s_q.mem_addr + (word ? ADDR_W'(2) : ADDR_W'(1));
               default: s_d.rdata = 16'h0000;
            endcase
         end
      end else if (!rd) begin
         s_d.drive = 1'b0;
      end
      if (srst) begin
         s_d = '0;
         s_d.gp_out = host_port_pkg::GP_OUT_RESET;
         s_d.vendor = host_port_pkg::VENDOR_ID_RESET;
         s_d.product = host_port_pkg::PRODUCT_ID_RESET;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // packet data reach the pins two edges after the strobe start and stand until release
   logic [15:0] out_word;
   assign out_word = s_q.rdata;
   assign data_low_lanes_out = out_word[7:0];
   assign data_low_lanes_oe_n = ~(s_q.drive & rd);

   // in 16-bit mode the high lanes are data; in 8-bit mode they carry wake, indicator, general outputs
   assign duplex_low = s_q.led_mode ? link_state.full_duplex : link_state.speed_10m;
   always_comb begin
      if (!s_q.straps.width8) begin
         data_high_lanes_out = out_word[15:8];
         data_high_lanes_oe_n = {8{~(s_q.drive & rd)}};
      end else begin
         // lane 0 wake, lane 1 indicator, lanes 2..4 general outputs 4..6, rest float
         data_high_lanes_out = {3'h0, s_q.gp_out, 1'b0, s_q.wake};
         data_high_lanes_oe_n = {3'h7, 3'h0, ~duplex_low, 1'b0};
      end
   end

   logic irq_active_low;
   assign irq_active_low = s_q.straps.irq_low ^ s_q.irq_inv;
   assign irq_out = irq_event ^ irq_active_low;
   // open-drain: drive only while the pin sits low; the high level comes from the pull-up
   assign irq_oe_n = (s_q.straps.width8 & s_q.straps.irq_open_drain) ? irq_out : 1'b0;
   assign reg_index = s_q.index;
   assign vendor_id = s_q.vendor;
   assign product_id = s_q.product;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_index_write: assert property (@(posedge clk) disable iff (srst)
      wr_start && !port_select |=> reg_index == $past(data_low_lanes_in)) else $error("index not taken");
   a_read_default: assert property (@(posedge clk) disable iff (srst)
      !s_q.read_inv && s_q.strap_done && sel && !host_read_strobe |-> rd) else $error("read strobe polarity");
   a_write_default: assert property (@(posedge clk) disable iff (srst)
      !s_q.write_inv && sel && host_write_strobe |-> !wr) else $error("write strobe polarity");
   a_irq_polarity: assert property (@(posedge clk) disable iff (srst)
      s_q.strap_done && !s_q.straps.irq_low && !s_q.irq_inv |-> irq_out == irq_event) else $error("irq polarity");
   a_irq_strap_low: assert property (@(posedge clk) disable iff (srst)
      s_q.straps.irq_low && !s_q.irq_inv && irq_event |-> !irq_out) else $error("irq not active low");
   a_gp_outputs: assert property (@(posedge clk) disable iff (srst)
      s_q.straps.width8 |-> data_high_lanes_out[4:2] == s_q.gp_out && data_high_lanes_oe_n[4:2] == 3'h0)
      else $error("general outputs wrong");
   a_indicator_float: assert property (@(posedge clk) disable iff (srst)
      s_q.straps.width8 && s_q.led_mode && !link_state.full_duplex |-> data_high_lanes_oe_n[1])
      else $error("indicator not floating");
   a_indicator_10m: assert property (@(posedge clk) disable iff (srst)
      s_q.straps.width8 && !s_q.led_mode && link_state.speed_10m
      |-> !data_high_lanes_oe_n[1] && !data_high_lanes_out[1]) else $error("indicator not low at 10M");
   a_mem_read: assert property (@(posedge clk) disable iff (srst)
      rd_start && mem_hit |=> ##1 data_low_lanes_out == $past(mem_rdata[7:0])) else $error("memory byte not shown");
   a_mem_step: assert property (@(posedge clk) disable iff (srst)
      mem_we && word |=> s_q.mem_addr == $past(s_q.mem_addr) + ADDR_W'(2)) else $error("word step wrong");
   a_id_load: assert property (@(posedge clk) disable iff (srst)
      id_load.vendor_valid |=> vendor_id == $past(id_load.vendor_id)) else $error("id not loaded");
endmodule : host_index_data_port

// ===== bench/host_bus_model.sv
// file: behavioural host processor on the index/data bus
`timescale 1ns/100ps
module host_bus_model (
   input wire logic clk,
   input wire logic [2:0] act_lvl,
   input wire logic [15:0] dev_out,
   input wire logic [15:0] dev_oe_n,
   output logic host_read_strobe,
   output logic host_write_strobe,
   output logic chip_select,
   output logic port_select,
   output logic [15:0] bus_in
);
   logic rd_on = 1'b0;
   logic wr_on = 1'b0;
   logic cs_on = 1'b0;
   logic drv_en = 1'b0;
   logic [15:0] drv = 16'h0000;
   initial port_select = 1'b0;
   // act_lvl holds the active levels of read, write and select
   assign host_read_strobe = rd_on ? act_lvl[2] : ~act_lvl[2];
   assign host_write_strobe = wr_on ? act_lvl[1] : ~act_lvl[1];
   assign chip_select = cs_on ? act_lvl[0] : ~act_lvl[0];
   // released lanes show the inverse of the last value, so a stale byte never passes
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         bus_in[i] = !dev_oe_n[i] ? dev_out[i] : (drv_en ? drv[i] : ~drv[i]);
      end
   end
   // index first, then data; strobe drops two full cycles between accesses
   task automatic write_cycle(input logic sel, input logic psel, input logic [15:0] d);
      @(negedge clk);
      port_select = psel;
      drv = d;
      drv_en = 1'b1;
      cs_on = sel;
      wr_on = 1'b1;
      repeat (2) @(negedge clk);
      wr_on = 1'b0;
      cs_on = 1'b0;
      drv_en = 1'b0;
      @(negedge clk);
   endtask : write_cycle
   task automatic read_cycle(input logic psel, output logic [15:0] q);
      @(negedge clk);
      port_select = psel;
      cs_on = 1'b1;
      rd_on = 1'b1;
      repeat (3) @(negedge clk);
      q = bus_in;
      rd_on = 1'b0;
      cs_on = 1'b0;
      @(negedge clk);
   endtask : read_cycle
endmodule : host_bus_model

// ===== bench/host_index_data_port_pins_tb_top.sv
// file: self-checking bench for the host index/data port
`timescale 1ns/100ps
module host_index_data_port_pins_tb_top;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] straps = 4'h0;
   logic [2:0] act_lvl = 3'h0;
   host_port_pkg::cfg_load_t cfg_load = '0;
   host_port_pkg::id_load_t id_load = '0;
   host_port_pkg::link_state_t link_state = '0;
   logic irq_event = 1'b0;
   logic wake_event = 1'b0;
   logic rd_s, wr_s, cs_s, psel, lo_oe_n, irq_out, irq_oe_n;
   logic [7:0] lo_out, hi_out, hi_oe_n, reg_index;
   logic [15:0] bus_in, vendor_id, product_id, q;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   initial forever #5 clk = ~clk;
   host_bus_model host_bus_model_i (.clk(clk), .act_lvl(act_lvl), .dev_out({hi_out, lo_out}),
      .dev_oe_n({hi_oe_n, {8{lo_oe_n}}}), .host_read_strobe(rd_s), .host_write_strobe(wr_s),
      .chip_select(cs_s), .port_select(psel), .bus_in(bus_in));
   host_index_data_port host_index_data_port_i (.clk(clk), .srst(srst), .host_read_strobe(rd_s),
      .host_write_strobe(wr_s), .chip_select(cs_s), .port_select(psel), .data_low_lanes_in(bus_in[7:0]),
      .data_low_lanes_out(lo_out), .data_low_lanes_oe_n(lo_oe_n), .data_high_lanes_in(bus_in[15:8]),
      .data_high_lanes_out(hi_out), .data_high_lanes_oe_n(hi_oe_n), .width_strap_pin(straps[3]),
      .irq_polarity_strap_pin(straps[2]), .wake_strap_pin(straps[1]), .irq_drive_type_strap(straps[0]),
      .cfg_load(cfg_load), .id_load(id_load), .link_state(link_state), .irq_event(irq_event),
      .wake_event(wake_event), .irq_out(irq_out), .irq_oe_n(irq_oe_n), .reg_index(reg_index),
      .vendor_id(vendor_id), .product_id(product_id));
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic end_of_test();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic do_reset(input logic [3:0] s);
      @(negedge clk);
      srst = 1'b1;
      straps = s;
      repeat (12) @(negedge clk);
      srst = 1'b0;
      repeat (2) @(negedge clk);
   endtask : do_reset
   task automatic set_cfg(input logic [4:0] c);
      @(negedge clk);
      cfg_load = {c, 1'b1};
      @(negedge clk);
      cfg_load = '0;
      @(negedge clk);
   endtask : set_cfg
   task automatic t_index();
      check("idle oe", 16'h1, {15'h0, lo_oe_n});
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h001f);
      check("index", 16'h1f, {8'h0, reg_index});
      host_bus_model_i.write_cycle(1'b1, 1'b1, 16'h0000);
      check("index kept", 16'h1f, {8'h0, reg_index});
      host_bus_model_i.write_cycle(1'b0, 1'b0, 16'h0028);
      check("deselected", 16'h1f, {8'h0, reg_index});
   endtask : t_index
   task automatic t_ids();
      @(negedge clk);
      id_load = {1'b1, 16'h1234, 16'h5678};
      @(negedge clk);
      id_load = '0;
      @(negedge clk);
      check("vendor", 16'h1234, vendor_id);
      check("product", 16'h5678, product_id);
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h0029);
      host_bus_model_i.read_cycle(1'b1, q);
      check("id read", 16'h12, {8'h0, q[7:0]});
   endtask : t_ids
   task automatic t_invert();
      set_cfg(5'b11000);
      act_lvl = 3'b110;
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h002a);
      check("inv write", 16'h2a, {8'h0, reg_index});
      host_bus_model_i.read_cycle(1'b1, q);
      check("inv read", 16'h78, {8'h0, q[7:0]});
      // idle levels are changed only where neither polarity makes select and strobe both active
      set_cfg(5'b11100);
      act_lvl = 3'b111;
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h002b);
      check("inv select", 16'h2b, {8'h0, reg_index});
      host_bus_model_i.write_cycle(1'b0, 1'b0, 16'h0028);
      check("inv deselect", 16'h2b, {8'h0, reg_index});
      act_lvl = 3'b110;
      set_cfg(5'b00000);
      act_lvl = 3'b000;
   endtask : t_invert
   task automatic t_mem();
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h00f4);
      host_bus_model_i.write_cycle(1'b1, 1'b1, 16'h0010);
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h00f2);
      host_bus_model_i.write_cycle(1'b1, 1'b1, 16'hbeef);
      host_bus_model_i.write_cycle(1'b1, 1'b1, 16'h1234);
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h00f4);
      host_bus_model_i.write_cycle(1'b1, 1'b1, 16'h0010);
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h00f2);
      host_bus_model_i.read_cycle(1'b1, q);
      check("mem word 0", 16'hbeef, q);
      host_bus_model_i.read_cycle(1'b1, q);
      check("mem word 1", 16'h1234, q);
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h00f4);
      host_bus_model_i.read_cycle(1'b1, q);
      check("mem addr word", 16'h0014, q);
   endtask : t_mem
   task automatic t_irq();
      irq_event = 1'b1;
      @(negedge clk);
      check("irq high", 16'h1, {15'h0, irq_out});
      check("irq drive", 16'h0, {15'h0, irq_oe_n});
      set_cfg(5'b00010);
      check("irq inv", 16'h0, {15'h0, irq_out});
      set_cfg(5'b00000);
      irq_event = 1'b0;
   endtask : t_irq
   task automatic t_8bit();
      do_reset(4'hf);
      act_lvl = 3'b001;
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h001f);
      host_bus_model_i.write_cycle(1'b1, 1'b1, 16'h0005);
      check("gp out", 16'h5, {13'h0, hi_out[4:2]});
      check("gp oe", 16'h0, {13'h0, hi_oe_n[4:2]});
      check("spare lanes", 16'h7, {13'h0, hi_oe_n[7:5]});
      check("irq idle od", 16'h1, {15'h0, irq_oe_n});
      irq_event = 1'b1;
      wake_event = 1'b1;
      repeat (2) @(negedge clk);
      check("irq low", 16'h0, {15'h0, irq_out});
      check("irq od", 16'h0, {15'h0, irq_oe_n});
      check("wake", 16'h1, {15'h0, hi_out[0]});
      link_state = 2'b01;
      @(negedge clk);
      check("ind 10m", 16'h0, {14'h0, hi_oe_n[1], hi_out[1]});
      link_state = 2'b10;
      @(negedge clk);
      check("ind 100m", 16'h2, {14'h0, hi_oe_n[1], 1'b0});
      set_cfg(5'b00001);
      check("ind full", 16'h0, {14'h0, hi_oe_n[1], hi_out[1]});
      link_state = 2'b01;
      @(negedge clk);
      check("ind half", 16'h2, {14'h0, hi_oe_n[1], 1'b0});
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h00f4);
      host_bus_model_i.write_cycle(1'b1, 1'b1, 16'h0020);
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h00f2);
      host_bus_model_i.write_cycle(1'b1, 1'b1, 16'h00a5);
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h00f4);
      host_bus_model_i.read_cycle(1'b1, q);
      check("mem addr byte", 16'h21, {8'h0, q[7:0]});
      host_bus_model_i.write_cycle(1'b1, 1'b1, 16'h0020);
      host_bus_model_i.write_cycle(1'b1, 1'b0, 16'h00f2);
      host_bus_model_i.read_cycle(1'b1, q);
      check("mem byte", 16'ha5, {8'h0, q[7:0]});
   endtask : t_8bit
   initial begin
      do_reset(4'h0);
      t_index();
      t_ids();
      t_invert();
      t_irq();
      t_mem();
      t_8bit();
      end_of_test();
   end
endmodule : host_index_data_port_pins_tb_top
